/* verilog/icap_pkg.sv */
// icap_pkg: register map, field layout and mode codes of the input capture unit
package icap_pkg;
  // register byte offsets on the wishbone bus
  localparam logic [4:0] ICAP_OFS_IRQ_EN    = 5'h00; // peripheral_irq_enable_three
  localparam logic [4:0] ICAP_OFS_STATUS    = 5'h04; // sticky event status, read clears
  localparam logic [4:0] ICAP_OFS_CTRL      = 5'h08; // channel modes, reset enables, quad select
  localparam logic [4:0] ICAP_OFS_TBASE     = 5'h0c; // time base count and enable
  localparam logic [4:0] ICAP_OFS_BUF1      = 5'h10;
  localparam logic [4:0] ICAP_OFS_BUF2      = 5'h14;
  localparam logic [4:0] ICAP_OFS_BUF3      = 5'h18;
  // enable / status bit positions
  localparam int ICAP_BIT_TB   = 0; // time_base_irq_enable
  localparam int ICAP_BIT_CH1  = 1; // ch1_irq_enable
  localparam int ICAP_BIT_CH2Q = 2; // ch2_or_quadrature_irq_enable
  localparam int ICAP_BIT_CH3D = 3; // ch3_or_direction_irq_enable
  localparam int ICAP_BIT_PWM  = 4; // pwm_timebase_irq_enable
  localparam logic [7:0] ICAP_IRQ_EN_MASK  = 8'h1f;
  localparam logic [7:0] ICAP_IRQ_EN_RESET = 8'h00;
  // control register layout: per channel 5 bits {reset_enable, mode[3:0]}
  localparam int ICAP_CTRL_CH_W    = 5;
  localparam int ICAP_CTRL_QUAD_LO = 15; // quadrature_mode_select[2:0]
  localparam logic [31:0] ICAP_CTRL_RESET = 32'h0000_0000;
  localparam int ICAP_TBASE_EN_BIT = 16;
  localparam logic [15:0] ICAP_TBASE_RESET = 16'h0000;
  // capture mode codes
  localparam logic [3:0] ICAP_MODE_OFF      = 4'h0;
  localparam logic [3:0] ICAP_MODE_EDGE_LO  = 4'h1;
  localparam logic [3:0] ICAP_MODE_EDGE_HI  = 4'h4;
  localparam logic [3:0] ICAP_MODE_PERIOD   = 4'h5;
  localparam logic [3:0] ICAP_MODE_PW_RISE  = 4'h6;
  localparam logic [3:0] ICAP_MODE_PW_FALL  = 4'h7;
  localparam logic [3:0] ICAP_MODE_STATE    = 4'h8;
  localparam logic [3:0] ICAP_MODE_SPECIAL0 = 4'he;
  localparam logic [3:0] ICAP_MODE_SPECIAL1 = 4'hf;
  // instruction cycle phase count
  localparam int ICAP_PHASES = 4;
  // phase state encoding, gray along the q1-q2-q3-q4 loop
  typedef enum logic [1:0] {
    ICAP_Q1 = 2'b00,
    ICAP_Q2 = 2'b01,
    ICAP_Q3 = 2'b11,
    ICAP_Q4 = 2'b10
  } icap_phase_t;
endpackage : icap_pkg

/* verilog/icap_phase_gen.sv */
// icap_phase_gen: four-phase instruction cycle sequencer for the capture unit
`timescale 1ns/10ps
module icap_phase_gen
  import icap_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  output logic      q2_rise,
  output logic      q4_rise
);
  icap_phase_t phase_q;
  icap_phase_t phase_d;

  // phase walks q1..q4 and wraps; every code is legal
  always_comb begin
    unique case (phase_q)
      ICAP_Q1: phase_d = ICAP_Q2;
      ICAP_Q2: phase_d = ICAP_Q3;
      ICAP_Q3: phase_d = ICAP_Q4;
      ICAP_Q4: phase_d = ICAP_Q1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= ICAP_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  // strobes mark the cycle in which that phase begins
  assign q2_rise = (phase_q == ICAP_Q2);
  assign q4_rise = (phase_q == ICAP_Q4);
endmodule // icap_phase_gen

/* verilog/icap_edge_decode.sv */
// icap_edge_decode: per-channel active-edge decode for the programmed capture mode
`timescale 1ns/10ps
module icap_edge_decode
  import icap_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sample,
  input  wire logic       pin,
  input  wire logic [3:0] mode,
  output logic            active,
  output logic            raises_flag
);
  logic       pin_q;
  logic [3:0] div_q;
  logic [3:0] div_d;
  logic       rise;
  logic       fall;
  logic       edge_any;
  logic       hit;

  // pin is looked at only on the q2 sample, later changes wait for the next one
  assign rise     = sample & pin & ~pin_q;
  assign fall     = sample & ~pin & pin_q;
  assign edge_any = rise | fall;

  // decode mode into the edge that counts
  always_comb begin
    hit = 1'b0;
    unique case (mode)
      4'h1:                                 hit = fall;
      4'h2:                                 hit = rise;
      4'h3:                                 hit = rise & (div_q[1:0] == 2'b11);
      4'h4:                                 hit = rise & (div_q == 4'hf);
      ICAP_MODE_PERIOD:                     hit = rise;
      ICAP_MODE_PW_RISE, ICAP_MODE_PW_FALL: hit = edge_any;
      ICAP_MODE_STATE:                      hit = edge_any;
      ICAP_MODE_SPECIAL0:                   hit = rise;
      ICAP_MODE_SPECIAL1:                   hit = fall;
      default:                              hit = 1'b0;
    endcase
  end

  // prescaler for every-4th / every-16th rising edge modes
  assign div_d = (mode == ICAP_MODE_OFF) ? 4'h0 : (rise ? div_q + 4'h1 : div_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_q <= 1'b0;
      div_q <= 4'h0;
    end else begin
      pin_q <= sample ? pin : pin_q;
      div_q <= div_d;
    end
  end

  assign active      = hit;
  // special event modes capture but never raise the channel flag
  assign raises_flag = (mode >= ICAP_MODE_EDGE_LO) && (mode <= ICAP_MODE_STATE);
endmodule // icap_edge_decode

/* verilog/icap_unit.sv */
// icap_unit: three-channel input capture with shared time base, wishbone registers and interrupt
//
// Functional notes
// - after a mode write, the first active edge latches the time base
// - every input edge is decoded against the mode to find active edges
// - every active edge overwrites the capture buffer with the time base
// - with reset enable set, the time base clears after each capture, except in the pulse-width modes
// - with reset enable clear, captures leave the time base untouched
// - after a capture reset the time base keeps counting on its own
// - capture repeats on every later active edge until mode change or reset
// - changing capture mode never alters the time base count
// - enable bit 3 gates channel three capture interrupt
// - in quadrature mode enable bit 3 gates direction change interrupt
// - enable bit 2 gates channel two or quadrature decoder interrupt
// - flags set in edge, period, pulse-width and state change modes only
// - edges sampled on phase two, acted on at phase four
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
module icap_unit
  import icap_pkg::*;
#(
  parameter int TB_W = 16
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // capture pins, channels 1..3
  input  wire logic [2:0]  cap_pin,
  // quadrature decoder events
  input  wire logic        quad_direction_event,
  input  wire logic        quad_decoder_event,
  // pwm time base event
  input  wire logic        pwm_timebase_event,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]      irq_en_q;
  logic [4:0]      status_q;
  logic [4:0]      status_d;
  logic [31:0]     ctrl_q;
  logic [TB_W-1:0] tbase_q;
  logic [TB_W-1:0] tbase_d;
  logic            tbase_run_q;
  logic [TB_W-1:0] buf_q [3];
  logic [2:0]      pend_q;
  logic            ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire         bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
  wire         wr        = bus_req & wb_we_i;
  wire         rd        = bus_req & ~wb_we_i;
  wire         sel_en    = (wb_adr_i == ICAP_OFS_IRQ_EN);
  wire         sel_stat  = (wb_adr_i == ICAP_OFS_STATUS);
  wire         sel_ctrl  = (wb_adr_i == ICAP_OFS_CTRL);
  wire         sel_tb    = (wb_adr_i == ICAP_OFS_TBASE);
  wire         wr_en     = wr & sel_en & wb_sel_i[0];
  wire         wr_tb     = wr & sel_tb;
  wire         rd_stat   = rd & sel_stat;
  wire [31:0]  wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0]  ctrl_next = (ctrl_q & ~wmask) | (wb_dat_i & wmask);

  // per channel control fields and quadrature select
  wire [2:0]   quad_sel  = ctrl_q[ICAP_CTRL_QUAD_LO +: 3];
  wire         quad_on   = (quad_sel != 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // phase sequencer
  logic q2_rise;
  logic q4_rise;

  icap_phase_gen u_phase (
    .clk     (clk),
    .rst     (rst),
    .q2_rise (q2_rise),
    .q4_rise (q4_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // channel decode and capture
  logic [2:0] active;
  logic [2:0] raises;
  logic [2:0] ch_reset_en;
  logic [2:0] fire;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ch
      wire [3:0] mode  = ctrl_q[g*ICAP_CTRL_CH_W +: 4];
      wire       ren   = ctrl_q[g*ICAP_CTRL_CH_W + 4];
      wire       is_pw = (mode == ICAP_MODE_PW_RISE) || (mode == ICAP_MODE_PW_FALL);

      icap_edge_decode u_dec (
        .clk         (clk),
        .rst         (rst),
        .sample      (q2_rise),
        .pin         (cap_pin[g]),
        .mode        (mode),
        .active      (active[g]),
        .raises_flag (raises[g])
      );

      assign ch_reset_en[g] = ren & ~is_pw;
      assign fire[g]        = q4_rise & pend_q[g];

      // latest capture overwrites the buffer; off mode drops a pending edge
      always_ff @(posedge clk) begin
        if (rst) begin
          buf_q[g]  <= '0;
          pend_q[g] <= 1'b0;
        end else begin
          pend_q[g] <= (mode == ICAP_MODE_OFF) ? 1'b0 : (active[g] | (pend_q[g] & ~q4_rise));
          if (fire[g]) begin
            buf_q[g] <= tbase_q;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // time base: software write, capture reset, or free count
  wire tb_clear = |(fire & ch_reset_en);
  always_comb begin
    if (wr_tb) begin
      tbase_d = wb_dat_i[TB_W-1:0];
    end else if (tb_clear) begin
      tbase_d = '0;
    end else if (tbase_run_q) begin
      tbase_d = tbase_q + 1'b1;
    end else begin
      tbase_d = tbase_q;
    end
  end
  wire tb_wrap = tbase_run_q & (&tbase_q) & ~tb_clear & ~wr_tb;

  always_ff @(posedge clk) begin
    if (rst) begin
      tbase_q     <= ICAP_TBASE_RESET;
      tbase_run_q <= 1'b0;
    end else begin
      tbase_q     <= tbase_d;
      tbase_run_q <= wr_tb ? wb_dat_i[ICAP_TBASE_EN_BIT] : tbase_run_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events: ch3 or direction change, ch2 or decoder, ch1, time base, pwm
  wire [4:0] evt;
  assign evt[ICAP_BIT_TB]   = tb_wrap;
  assign evt[ICAP_BIT_CH1]  = fire[0] & raises[0];
  assign evt[ICAP_BIT_CH2Q] = quad_on ? quad_decoder_event : (fire[1] & raises[1]);
  assign evt[ICAP_BIT_CH3D] = quad_on ? quad_direction_event : (fire[2] & raises[2]);
  assign evt[ICAP_BIT_PWM]  = pwm_timebase_event;

  // read clears status, but an event in the same cycle wins
  assign status_d = (rd_stat ? 5'h00 : status_q) | evt;

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_en_q <= ICAP_IRQ_EN_RESET;
      ctrl_q   <= ICAP_CTRL_RESET;
      status_q <= 5'h00;
    end else begin
      irq_en_q <= wr_en ? (wb_dat_i[7:0] & ICAP_IRQ_EN_MASK) : irq_en_q;
      ctrl_q   <= (wr & sel_ctrl) ? ctrl_next : ctrl_q;
      status_q <= status_d;
    end
  end

  // level interrupt only while an enabled flag stands
  assign irq = |(status_q & irq_en_q[4:0]);

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero and still ack
  logic [31:0] rdata;
  always_comb begin
    unique case (wb_adr_i)
      ICAP_OFS_IRQ_EN: rdata = {24'h0, irq_en_q};
      ICAP_OFS_STATUS: rdata = {27'h0, status_q};
      ICAP_OFS_CTRL:   rdata = ctrl_q;
      ICAP_OFS_TBASE:  rdata = {15'h0, tbase_run_q, 16'(tbase_q)};
      ICAP_OFS_BUF1:   rdata = {16'h0, 16'(buf_q[0])};
      ICAP_OFS_BUF2:   rdata = {16'h0, 16'(buf_q[1])};
      ICAP_OFS_BUF3:   rdata = {16'h0, 16'(buf_q[2])};
      default:         rdata = 32'h0;
    endcase
  end

  // one registered ack per request, the cycle after it, dropped the cycle after
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_q    <= bus_req;
      wb_dat_o <= bus_req ? rdata : wb_dat_o;
    end
  end
  assign wb_ack_o = ack_q;
endmodule // icap_unit

/* tb/icap_unit_asserts.sv */
// icap_unit_asserts: port-level checks of the input capture unit
`timescale 1ns/10ps
module icap_unit_asserts
  import icap_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [4:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [2:0]  cap_pin,
  input wire logic        quad_direction_event,
  input wire logic        quad_decoder_event,
  input wire logic        pwm_timebase_event,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // cycles since the last possible irq cause; saturates so it never wraps
  // limitation: a time base wrap is not seen here, keep wraps out of such runs
  logic [3:0] quiet_q;
  logic       cause;
  assign cause = pwm_timebase_event | quad_decoder_event | quad_direction_event | (wb_cyc_i & wb_stb_i & wb_we_i);
  always_ff @(posedge clk) begin
    if (rst || cause || cap_pin != $past(cap_pin)) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_ack_take; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_take: assert property (p_ack_take)
    else $error("ack missing after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_dat_hold; !(wb_cyc_i && wb_stb_i) && !wb_ack_o |=> $stable(wb_dat_o); endproperty
  a_dat_hold: assert property (p_dat_hold)
    else $error("read data moved while idle");
  property p_en_zero; wb_ack_o && !wb_we_i && wb_adr_i == ICAP_OFS_IRQ_EN |-> wb_dat_o[31:5] == 27'h0; endproperty
  a_en_zero: assert property (p_en_zero)
    else $error("unused enable bits not zero");
  property p_unmapped; wb_ack_o && !wb_we_i && wb_adr_i > ICAP_OFS_BUF3 |-> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_reset_quiet; @(posedge clk) disable iff (1'b0) rst |=> !wb_ack_o && !irq; endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("ack or irq after reset");
  property p_irq_cause; $rose(irq) |-> quiet_q <= 4'h8; endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq rose without recent cause");
endmodule // icap_unit_asserts

/* tb/icap_pin_model.sv */
// icap_pin_model: far-side source of the three capture pin levels
`timescale 1ns/10ps
module icap_pin_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] flip,
  output logic      [2:0] cap_pin
);
  // pins move only on a clock edge, the unit samples synchronous levels
  always_ff @(posedge clk) begin
    if (rst) begin
      cap_pin <= 3'h0;
    end else begin
      cap_pin <= cap_pin ^ flip;
    end
  end
endmodule // icap_pin_model

/* tb/testbench.sv */
// testbench: register, capture and interrupt tests of the input capture unit
`timescale 1ns/10ps
module testbench
  import icap_pkg::*;
;
  typedef struct packed {logic w; logic [4:0] a; logic [31:0] d; logic [31:0] e;} icap_row_t;
  logic        clk, rst, cyc, stb, we, ack, irq;
  logic [4:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rdat, r, b1, b2, t0, t1;
  logic [2:0]  flip, pins, evt;
  int          bad_count, num_checks;
  icap_row_t   rows [10];
  logic [3:0]  modes [11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'he, 4'hf};
  logic [31:0] bits [3] = '{32'h10, 32'h4, 32'h8};
  icap_pin_model pin_u (.clk(clk), .rst(rst), .flip(flip), .cap_pin(pins));
  icap_unit dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .cap_pin(pins),
    .quad_direction_event(evt[2]), .quad_decoder_event(evt[1]), .pwm_timebase_event(evt[0]), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // level held long enough for two phase-two samples
  task automatic pin(input logic [2:0] f);
    @(posedge clk);
    flip <= f;
    @(posedge clk);
    flip <= 3'h0;
    repeat (8) @(posedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // whole run needs about 4000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    {cyc, stb, we, adr, sel, dat, flip, evt} = '0;
    rows = '{'{1'b0, ICAP_OFS_IRQ_EN, 32'h0, 32'h0}, '{1'b0, ICAP_OFS_CTRL, 32'h0, 32'h0},
      '{1'b0, ICAP_OFS_TBASE, 32'h0, 32'h0}, '{1'b0, ICAP_OFS_STATUS, 32'h0, 32'h0},
      '{1'b0, ICAP_OFS_BUF3, 32'h0, 32'h0}, '{1'b1, ICAP_OFS_IRQ_EN, 32'hffffffff, 32'h0},
      '{1'b0, ICAP_OFS_IRQ_EN, 32'h0, 32'h1f}, '{1'b1, 5'h1c, 32'hffffffff, 32'h0},
      '{1'b0, 5'h1c, 32'h0, 32'h0}, '{1'b1, ICAP_OFS_IRQ_EN, 32'h0, 32'h0}};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk($sformatf("reg %h", rows[i].a), r, rows[i].e);
    end
    // ch1 rising capture with base clear, then a shorter second interval
    wb(1'b1, ICAP_OFS_CTRL, 32'h12);
    wb(1'b1, ICAP_OFS_TBASE, 32'h1_0000);
    repeat (150) @(posedge clk);
    pin(3'h1);
    wb(1'b0, ICAP_OFS_BUF1, 32'h0);
    b1 = r;
    wb(1'b0, ICAP_OFS_TBASE, 32'h0);
    chk("first capture", {31'h0, b1[15:0] > 16'h10}, 32'h1);
    chk("base cleared", {31'h0, r[15:0] < b1[15:0]}, 32'h1);
    pin(3'h1);
    pin(3'h1);
    wb(1'b0, ICAP_OFS_BUF1, 32'h0);
    chk("recapture", {31'h0, r[15:0] < b1[15:0] && r[15:0] != 16'h0}, 32'h1);
    // ch2 capture without clear, then mode switched out and back
    wb(1'b1, ICAP_OFS_CTRL, 32'h40);
    wb(1'b0, ICAP_OFS_TBASE, 32'h0);
    t0 = r;
    pin(3'h2);
    wb(1'b0, ICAP_OFS_BUF2, 32'h0);
    b2 = r;
    wb(1'b0, ICAP_OFS_TBASE, 32'h0);
    t1 = r;
    chk("base kept", {31'h0, t1[15:0] > b2[15:0] && b2[15:0] >= t0[15:0]}, 32'h1);
    wb(1'b1, ICAP_OFS_CTRL, 32'h0);
    wb(1'b1, ICAP_OFS_CTRL, 32'h40);
    wb(1'b0, ICAP_OFS_TBASE, 32'h0);
    chk("mode switch", {31'h0, r[15:0] > t1[15:0]}, 32'h1);
    // mode codes 1 to 9, e and f on ch3: only the first eight raise the flag
    wb(1'b1, ICAP_OFS_IRQ_EN, 32'h8);
    foreach (modes[m]) begin
      wb(1'b1, ICAP_OFS_CTRL, {18'h0, modes[m], 10'h0});
      wb(1'b0, ICAP_OFS_STATUS, 32'h0);
      repeat (32) pin(3'h4);
      chk($sformatf("irq mode %h", modes[m]), {31'h0, irq}, {31'h0, m < 8});
      wb(1'b0, ICAP_OFS_STATUS, 32'h0);
      chk("flag", r & 32'h8, (m < 8) ? 32'h8 : 32'h0);
      chk("irq cleared", {31'h0, irq}, 32'h0);
    end
    // pwm, decoder and direction events: masked, unmasked, flag read back
    wb(1'b1, ICAP_OFS_CTRL, 32'h8000);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, ICAP_OFS_IRQ_EN, 32'h0);
      wb(1'b0, ICAP_OFS_STATUS, 32'h0);
      evt <= 3'(1 << i);
      @(posedge clk);
      evt <= 3'h0;
      repeat (3) @(posedge clk);
      chk("masked irq", {31'h0, irq}, 32'h0);
      wb(1'b1, ICAP_OFS_IRQ_EN, bits[i]);
      chk("unmasked irq", {31'h0, irq}, 32'h1);
      wb(1'b0, ICAP_OFS_STATUS, 32'h0);
      chk("event flag", r, bits[i]);
    end
    // pulse-width mode on ch1 with reset enable set: the base must keep counting
    wb(1'b1, ICAP_OFS_CTRL, 32'h16);
    wb(1'b0, ICAP_OFS_TBASE, 32'h0);
    t0 = r;
    pin(3'h1);
    wb(1'b0, ICAP_OFS_BUF1, 32'h0);
    b1 = r;
    wb(1'b0, ICAP_OFS_TBASE, 32'h0);
    chk("pw capture", {31'h0, b1[15:0] > t0[15:0]}, 32'h1);
    chk("pw no clear", {31'h0, r[15:0] > b1[15:0]}, 32'h1);
    // reset in mid-run clears enables and stops the base
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, ICAP_OFS_IRQ_EN, 32'h0);
    chk("enable after reset", r, 32'h0);
    wb(1'b0, ICAP_OFS_TBASE, 32'h0);
    chk("base after reset", r, 32'h0);
    finish_test();
  end
endmodule // testbench

bind icap_unit icap_unit_asserts chk_u (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .cap_pin, .quad_direction_event, .quad_decoder_event, .pwm_timebase_event, .irq);
